// ---- core/lvd_ctrl.sv ----
// Purpose: Low-voltage detect control register, status flags, reset and
//          interrupt outputs behind an Avalon-MM slave.
// Assumes: Comparator inputs are synchronous to clk_i; rst_n_i is the
//          power-on or watchdog reset, which alone clears the sticky bits.
// Notes:   Every access is answered one cycle after it is first seen.
`timescale 1ns/100ps

// How it works
// - Control bit 7 turns the detector on; when 0 no reset or interrupt comes out.
// - Control bits 6 to 4 read as 1 and ignore writes.
// - Control bit 3 picks the threshold sent to the comparator: 0 low, 1 high.
// - Control bit 2 lets a supply drop below the level reset the chip.
// - Control bit 1, reset to 0, enables the falling-supply interrupt.
// - Control bit 0, reset to 0, enables the rising-supply interrupt.
// - Bits 7, 3 and 2 survive a low-voltage reset and clear only on power-on or watchdog reset.
// - After recovery from a low-voltage reset, release follows 131,072 clock cycles.
// - Apart from resets, a fall or rise flag clears only by writing 0 after reading it as 1.
module lvd_ctrl
  import lvd_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = RELEASE_CYCLES
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              below_reset_i,
  input  wire logic              fall_detect_i,
  input  wire logic              rise_detect_i,
  output logic                   detector_enable_o,
  output logic                   reset_level_select_o,
  output logic                   low_voltage_reset_o,
  output logic                   low_voltage_irq_o
);
  lvd_ctrl_t  ctrl;
  lvd_ctrl_t  next_ctrl;
  lvd_flags_t flags;
  logic       lv_reset;
  logic       served;

  // Requests wait one cycle; waitrequest drops for the accepting edge.
  wire req       = avs_read_i | avs_write_i;
  wire accept    = req && served;
  wire capture   = req && !served;
  wire hit_ctrl  = avs_address_i == CTRL_OFS;
  wire hit_stat  = avs_address_i == STATUS_OFS;
  wire hit_pend  = avs_address_i == PEND_OFS;
  wire lane0     = avs_byteenable_i[0];
  wire wr_ctrl   = accept && avs_write_i && hit_ctrl && lane0;
  wire wr_stat   = accept && avs_write_i && hit_stat && lane0;
  // Arm on the edge that latches read data, so software saw the same value.
  wire rd_stat   = capture && avs_read_i && hit_stat;

  wire [7:0] wd = avs_writedata_i[7:0];

  // Low-voltage reset keeps the sticky control bits but clears the rest.
  always_comb begin
    next_ctrl            = ctrl;
    if (lv_reset) begin
      next_ctrl.fall_en  = 1'b0;
      next_ctrl.rise_en  = 1'b0;
    end else if (wr_ctrl) begin
      next_ctrl.enable     = wd[ENABLE_BIT];
      next_ctrl.level_high = wd[LEVEL_BIT];
      next_ctrl.reset_en   = wd[RSTEN_BIT];
      next_ctrl.fall_en    = wd[FALLEN_BIT];
      next_ctrl.rise_en    = wd[RISEEN_BIT];
    end
  end

  wire [7:0] ctrl_rd = CTRL_RSVD_MASK
                     | {ctrl.enable, 3'b000, ctrl.level_high,
                        ctrl.reset_en, ctrl.fall_en, ctrl.rise_en};
  wire [7:0] stat_rd = STATUS_RSVD | {6'h00, flags.fall, flags.rise};
  wire [7:0] pend_rd = {6'h00, low_voltage_irq_o, lv_reset};
  wire [7:0] rd_sel  = hit_ctrl ? ctrl_rd :
                       hit_stat ? stat_rd :
                       hit_pend ? pend_rd : 8'h00;

  // Flags follow the comparators only while the detector runs; the rise flag also needs rise_en.
  wire set_fall = ctrl.enable && fall_detect_i;
  wire set_rise = ctrl.enable && rise_detect_i && ctrl.rise_en;
  wire trip     = ctrl.enable && ctrl.reset_en && below_reset_i;

  // The flags are cleared by the low-voltage reset as well.
  wire flag_rst_n = rst_n_i && !lv_reset;

  lvd_flag u_fall (
    .clk_i     (clk_i),
    .rst_n_i   (flag_rst_n),
    .set_i     (set_fall),
    .read_i    (rd_stat),
    .wr_zero_i (wr_stat && !wd[FALLF_BIT]),
    .flag_o    (flags.fall)
  );

  lvd_flag u_rise (
    .clk_i     (clk_i),
    .rst_n_i   (flag_rst_n),
    .set_i     (set_rise),
    .read_i    (rd_stat),
    .wr_zero_i (wr_stat && !wd[RISEF_BIT]),
    .flag_o    (flags.rise)
  );

  lvd_release #(
    .CYCLES (HOLD_CYCLES)
  ) u_release (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .trip_i  (trip),
    .below_i (below_reset_i),
    .reset_o (lv_reset)
  );

  wire irq_now = ctrl.enable
               && ((flags.fall && ctrl.fall_en)
                   || (flags.rise && ctrl.rise_en));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      served            <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      served            <= req && !served;
      avs_waitrequest_o <= !(req && !served);
      if (req && !served) begin
        avs_readdata_o <= {24'h000000, rd_sel};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      detector_enable_o    <= 1'b0;
      reset_level_select_o <= 1'b0;
      low_voltage_reset_o  <= 1'b0;
      low_voltage_irq_o    <= 1'b0;
    end else begin
      detector_enable_o    <= ctrl.enable;
      reset_level_select_o <= ctrl.level_high;
      low_voltage_reset_o  <= lv_reset;
      low_voltage_irq_o    <= irq_now;
    end
  end
endmodule

// ---- shared/lvd_pkg.sv ----
// Purpose: Constants and types shared by the low-voltage detect control block.
// Assumes: Avalon-MM slave with 32-bit data, word addressing by byte offset.
// Notes:   Timing counts derive from the 250 MHz system clock.
package lvd_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] PEND_OFS   = 4'h8;

  localparam int unsigned ENABLE_BIT  = 7;
  localparam int unsigned LEVEL_BIT   = 3;
  localparam int unsigned RSTEN_BIT   = 2;
  localparam int unsigned FALLEN_BIT  = 1;
  localparam int unsigned RISEEN_BIT  = 0;
  localparam int unsigned FALLF_BIT   = 1;
  localparam int unsigned RISEF_BIT   = 0;

  localparam logic [7:0] CTRL_RSVD_MASK  = 8'h70;
  localparam logic [7:0] STATUS_RSVD     = 8'hFC;
  localparam logic [7:0] CTRL_RESET      = 8'h70;

  localparam int unsigned RELEASE_CYCLES = 131072;

  typedef struct packed {
    logic enable;
    logic level_high;
    logic reset_en;
    logic fall_en;
    logic rise_en;
  } lvd_ctrl_t;

  typedef struct packed {
    logic fall;
    logic rise;
  } lvd_flags_t;

  typedef enum logic [1:0] {
    LVD_RUN     = 2'b00,
    LVD_HELD    = 2'b01,
    LVD_COUNT   = 2'b10
  } lvd_rst_state_t;

endpackage

// ---- core/lvd_flag.sv ----
// Purpose: One sticky voltage-event flag with read-then-write-zero clear.
// Assumes: Clear attempts arrive as one-cycle pulses from the bus slave.
// Notes:   A set in the cycle of a clear wins.
`timescale 1ns/100ps
module lvd_flag
  import lvd_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic read_i,
  input  wire logic wr_zero_i,
  output logic      flag_o
);
  logic armed;
  wire  clear_ok = wr_zero_i && armed;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
      armed  <= 1'b0;
    end else begin
      if (set_i) begin
        flag_o <= 1'b1;
      end else if (clear_ok) begin
        flag_o <= 1'b0;
      end
      if (clear_ok || set_i) begin
        armed <= 1'b0;
      end else if (read_i && flag_o) begin
        armed <= 1'b1;
      end
    end
  end
endmodule

// ---- core/lvd_release.sv ----
// Purpose: Counts the hold-off after a low-voltage reset before release.
// Assumes: below_i is the comparator level, already in the clock domain.
// Notes:   Counting restarts whenever the supply drops again.
`timescale 1ns/100ps
module lvd_release
  import lvd_pkg::*;
#(
  parameter int unsigned CYCLES = RELEASE_CYCLES
)
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic trip_i,
  input  wire logic below_i,
  output logic      reset_o
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  lvd_rst_state_t state;
  logic [CW-1:0]  count;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state   <= LVD_RUN;
      count   <= '0;
      reset_o <= 1'b0;
    end else begin
      case (state)
        LVD_RUN: begin
          if (trip_i) begin
            state   <= LVD_HELD;
            reset_o <= 1'b1;
          end
        end
        LVD_HELD: begin
          count <= '0;
          if (!below_i) begin
            state <= LVD_COUNT;
          end
        end
        LVD_COUNT: begin
          if (below_i) begin
            state <= LVD_HELD;
          end else if (count == LAST) begin
            state   <= LVD_RUN;
            reset_o <= 1'b0;
          end else begin
            count <= count + 1'b1;
          end
        end
        default: begin
          state <= LVD_RUN;
        end
      endcase
    end
  end
endmodule

// ---- sim/lvd_ctrl_properties.sv ----
// Purpose: Port-level assertions for lvd_ctrl.
// Assumes: Bound to every lvd_ctrl instance.
// Notes:   Figures follow the bus and hold-off timing of the block.
`timescale 1ns/100ps
module lvd_ctrl_properties
  import lvd_pkg::*;
#(parameter int unsigned HOLD_CYCLES = RELEASE_CYCLES)
(
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [31:0]       avs_writedata_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic [31:0]       avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic              below_reset_i,
  input wire logic              detector_enable_o,
  input wire logic              reset_level_select_o,
  input wire logic              low_voltage_reset_o,
  input wire logic              low_voltage_irq_o
);
  logic [31:0] low_run;
  wire req = avs_read_i || avs_write_i;
  wire ctl = req && !avs_waitrequest_o && avs_address_i == CTRL_OFS;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Counts cycles of recovered supply while the low-voltage reset is held.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || below_reset_i || !low_voltage_reset_o) begin
      low_run <= 32'h0000_0000;
    end else begin
      low_run <= low_run + 32'h0000_0001;
    end
  end
  a_wait_single: assert property ($fell(avs_waitrequest_o) |=>
    avs_waitrequest_o) else $error("wait low too long");
  a_req_answer: assert property (req && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("request not answered");
  a_idle_wait: assert property (!req |=> avs_waitrequest_o)
    else $error("wait low when idle");
  a_rsvd_ones: assert property (ctl && avs_read_i |->
    avs_readdata_o[31:8] == 24'h000000 && avs_readdata_o[6:4] == 3'h7)
    else $error("control read wrong");
  a_ctrl_load: assert property (ctl && avs_write_i &&
    avs_byteenable_i[0] && !low_voltage_reset_o |->
    ##2 {detector_enable_o, reset_level_select_o}
    == {$past(avs_writedata_i[7], 2), $past(avs_writedata_i[3], 2)})
    else $error("control outputs wrong");
  a_standby_quiet: assert property (!detector_enable_o &&
    !$past(detector_enable_o) |-> !low_voltage_irq_o && !low_voltage_reset_o)
    else $error("output while in standby");
  a_trip_cause: assert property ($rose(low_voltage_reset_o) |->
    $past(below_reset_i) || $past(below_reset_i, 2)) else $error("bad trip");
  a_release_hold: assert property (low_run != 32'h0 &&
    low_run <= HOLD_CYCLES |-> low_voltage_reset_o)
    else $error("reset released early");
  a_release_end: assert property (low_run == HOLD_CYCLES + 1 &&
    !below_reset_i |=> !low_voltage_reset_o)
    else $error("reset held too long");
  c_ctrl: cover property (ctl && avs_write_i);
  c_trip: cover property ($rose(low_voltage_reset_o));
  c_irq: cover property ($rose(low_voltage_irq_o));
endmodule

bind lvd_ctrl lvd_ctrl_properties #(.HOLD_CYCLES(HOLD_CYCLES)) props_u (.*);

// ---- sim/lvd_supply_model.sv ----
// Purpose: Supply comparators facing lvd_ctrl.
// Assumes: supply_i is the supply in tenths of a volt.
// Notes:   Comparators run even in standby; gating is the block's job.
`timescale 1ns/100ps
module lvd_supply_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] supply_i,
  input  wire logic       level_high_i,
  output logic            below_o,
  output logic            fall_o,
  output logic            rise_o
);
  logic dropped = 1'b0;
  assign below_o = supply_i < (level_high_i ? 8'h24 : 8'h17);
  assign fall_o  = supply_i < 8'h25;
  assign rise_o  = dropped && supply_i > 8'h28;
  always @(posedge clk_i) dropped <= fall_o || (dropped && !rise_o);
endmodule

// ---- sim/lvd_ctrl_tb.sv ----
// Purpose: Self-checking bench for lvd_ctrl.
// Assumes: Hold-off shortened to 16 cycles.
// Notes:   Reads are queued and compared by a monitor.
`timescale 1ns/100ps
module lvd_ctrl_tb import lvd_pkg::*; ;
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              avs_read_i = 1'b0;
  logic              avs_write_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = 4'h0;
  logic [31:0]       avs_writedata_i = 32'h0;
  logic [3:0]        avs_byteenable_i = 4'hF;
  logic [7:0]        supply = 8'h32;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o, below_reset_i, fall_detect_i;
  logic              rise_detect_i, detector_enable_o, reset_level_select_o;
  logic              low_voltage_reset_o, low_voltage_irq_o;
  logic [31:0]       exp_q[$];
  int                fail_count = 0, checks_done = 0, seed = 6378;
  always #2 clk_i = ~clk_i;
  lvd_ctrl #(.HOLD_CYCLES(16)) dut_u (.*);
  lvd_supply_model part_u (.clk_i(clk_i), .supply_i(supply),
    .level_high_i(reset_level_select_o), .below_o(below_reset_i),
    .fall_o(fall_detect_i), .rise_o(rise_detect_i));
  task automatic check(string nm, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Reserved bits 6:4 and the upper bytes carry random values.
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d, logic [7:0] e);
    if (!w) exp_q.push_back({24'h0, e});
    avs_address_i   <= a;
    avs_writedata_i <= {24'($random(seed)), d[7], 3'($random(seed)), d[3:0]};
    avs_read_i      <= !w;
    avs_write_i     <= w;
    @(posedge clk_i);
    repeat (50) if (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    check("waitrequest", 32'h0, {31'h0, avs_waitrequest_o});
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_rst(logic v);
    repeat (100) if (low_voltage_reset_o !== v) @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && exp_q.size() > 0)
      check("readdata", exp_q.pop_front(), avs_readdata_o);
  end
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, CTRL_OFS, 8'h00, 8'h70);
    bus(1'b0, STATUS_OFS, 8'h00, 8'hFC);
    bus(1'b1, 4'hC, 8'hFF, 8'h00);
    bus(1'b0, 4'hC, 8'h00, 8'h00);
    avs_byteenable_i <= 4'hE;
    bus(1'b1, CTRL_OFS, 8'h8C, 8'h00);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, CTRL_OFS, 8'h00, 8'h70);
    $display("reset test done");
    bus(1'b1, CTRL_OFS, 8'h83, 8'h00);
    supply <= 8'h21;
    repeat (4) @(posedge clk_i);
    supply <= 8'h32;
    repeat (4) @(posedge clk_i);
    check("irq", 32'h1, {31'h0, low_voltage_irq_o});
    bus(1'b1, STATUS_OFS, 8'h00, 8'h00);
    bus(1'b0, STATUS_OFS, 8'h00, 8'hFF);
    bus(1'b1, STATUS_OFS, 8'hFD, 8'h00);
    bus(1'b0, STATUS_OFS, 8'h00, 8'hFD);
    check("irq", 32'h1, {31'h0, low_voltage_irq_o});
    bus(1'b1, STATUS_OFS, 8'hFC, 8'h00);
    bus(1'b0, STATUS_OFS, 8'h00, 8'hFC);
    check("irq", 32'h0, {31'h0, low_voltage_irq_o});
    $display("flag test done");
    bus(1'b1, CTRL_OFS, 8'h8C, 8'h00);
    bus(1'b0, CTRL_OFS, 8'h00, 8'hFC);
    check("level", 32'h1, {31'h0, reset_level_select_o});
    check("enable", 32'h1, {31'h0, detector_enable_o});
    bus(1'b1, CTRL_OFS, 8'h87, 8'h00);
    supply <= 8'h14;
    wait_rst(1'b1);
    check("lv_reset", 32'h1, {31'h0, low_voltage_reset_o});
    bus(1'b0, PEND_OFS, 8'h00, 8'h01);
    supply <= 8'h32;
    wait_rst(1'b0);
    check("lv_reset", 32'h0, {31'h0, low_voltage_reset_o});
    bus(1'b0, CTRL_OFS, 8'h00, 8'hF4);
    bus(1'b0, STATUS_OFS, 8'h00, 8'hFC);
    $display("low-voltage reset test done");
    bus(1'b1, CTRL_OFS, 8'h07, 8'h00);
    supply <= 8'h14;
    repeat (20) @(posedge clk_i);
    check("lv_reset", 32'h0, {31'h0, low_voltage_reset_o});
    check("irq", 32'h0, {31'h0, low_voltage_irq_o});
    check("enable", 32'h0, {31'h0, detector_enable_o});
    $display("standby test done");
    supply  <= 8'h32;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b0, CTRL_OFS, 8'h00, 8'h70);
    $display("power-on reset test done");
    print_verdict();
  end
endmodule
